// ### tb/host_model.sv
// model: host that reads and clears the fault flags a while after a fault
// assumes the clear pulse is sampled on the rising clock edge
`timescale 1ns/10ps
module host_model
    import reg_sup_pkg::*;
(
    input  wire logic                         i_clock,
    input  wire logic                         i_nrst,
    input  wire logic                         i_arm,
    input  wire logic [7:0]                   i_delay,
    input  wire logic                         i_fault_out,
    input  wire logic [NUM_CH-1:0][F_W-1:0]   i_flags,
    output logic      [NUM_CH-1:0][F_W-1:0]   o_clear
);
    logic [7:0] wait_cnt;
    // clear exactly the bits read, once the chosen delay has passed
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            wait_cnt <= 8'h00;
            o_clear  <= '0;
        end else if (i_arm && (i_fault_out || |i_flags) && wait_cnt >= i_delay) begin
            wait_cnt <= 8'h00;
            o_clear  <= i_flags;
        end else begin
            wait_cnt <= wait_cnt + 8'h01;
            o_clear  <= '0;
        end
    end
endmodule // host_model

// ### tb/sup_chk.sv
// checker: port-level properties of the regulator fault supervisor
// assumes one clock domain; bound to every instance of the design
`timescale 1ns/10ps
module sup_chk
    import reg_sup_pkg::*;
(
    input wire logic                           i_clock,
    input wire logic                           i_nrst,
    input wire logic                           i_otp_b_is_main,
    input wire logic [CODE_W-1:0]              i_otp_b_vcode,
    input wire logic [NUM_CH-1:0][THR_W-1:0]   i_vout_level,
    input wire logic [NUM_CH-1:0][THR_W-1:0]   i_spi_uv_thr,
    input wire logic [NUM_CH-1:0][F_W-1:0]     i_spi_clear,
    input wire logic [NUM_CH-1:0]              i_ground_loss,
    input wire logic                           i_spi_wr_ss_disable,
    input wire logic [NUM_CH-1:0]              i_spi_ss_disable,
    input wire logic [SLEW_W-1:0]              i_spi_b_slew_rise,
    input wire logic                           o_fault_out,
    input wire logic                           o_reset_out_n,
    input wire logic [1:0]                     o_dev_state,
    input wire logic [NUM_CH-1:0]              o_stage_on,
    input wire logic [NUM_CH-1:0]              o_spread_en,
    input wire logic [NUM_CH-1:0][PHASE_W-1:0] o_phase,
    input wire logic [CODE_W-1:0]              o_b_vcode,
    input wire logic [SLEW_W-1:0]              o_b_slew_rise,
    input wire logic [NUM_CH-1:0][F_W-1:0]     o_fault_flags
);
    default clocking @(posedge i_clock);
    endclocking
    default disable iff (!i_nrst);

    a_uv_flag_set: assert property (
        o_stage_on[CH_C] && i_vout_level[CH_C] < i_spi_uv_thr[CH_C] |-> ##[1:4] o_fault_flags[CH_C][F_UV])
        else $error("uv flag not set");
    a_flag_raises_fault: assert property (
        $rose(|o_fault_flags) |-> o_fault_out)
        else $error("fault pin not raised with flag");
    a_flags_sticky: assert property (
        (($past(o_fault_flags) & ~$past(i_spi_clear)) & ~o_fault_flags) == '0)
        else $error("fault flag dropped without clear");
    a_main_uv_reset: assert property (
        i_otp_b_is_main && $rose(o_fault_flags[CH_B][F_UV]) |-> !o_reset_out_n && o_dev_state == ST_RECOVER)
        else $error("main undervoltage without reset");
    a_ot_stage_off: assert property (
        $past(o_fault_flags[CH_BOOST][F_OT]) && o_fault_flags[CH_BOOST][F_OT] |-> !o_stage_on[CH_BOOST])
        else $error("stage on with over-temperature flag");
    a_gl_post_off: assert property (
        $past(o_fault_flags[CH_D][F_GL]) && o_fault_flags[CH_D][F_GL] |-> !o_stage_on[CH_D])
        else $error("stage on with ground loss flag");
    a_main_gl_all_off: assert property (
        i_otp_b_is_main && $past(i_ground_loss[CH_B], 3) |-> o_stage_on == '0)
        else $error("stages on during main ground loss");
    a_phase_fixed: assert property (
        o_phase[CH_B] == 2'h2 && o_phase[CH_C] == 2'h1 && o_phase[CH_D] == 2'h3 && o_phase[CH_BOOST] == 2'h3)
        else $error("phase offsets wrong");
    a_spread_by_write: assert property (
        ((~o_spread_en & $past(o_spread_en) & ~($past(i_spi_ss_disable) & {NUM_CH{$past(i_spi_wr_ss_disable)}}))
        | ($past(~o_spread_en) & o_spread_en)) == '0)
        else $error("spread enable changed without write");
    a_config_load: assert property (
        1'b1 |=> o_b_vcode == $past(i_otp_b_vcode) && o_b_slew_rise == $past(i_spi_b_slew_rise))
        else $error("config output not loaded");
endmodule // sup_chk

bind regulator_fault_supervisor sup_chk sup_chk_i (.i_clock, .i_nrst, .i_otp_b_is_main, .i_otp_b_vcode,
    .i_vout_level, .i_spi_uv_thr, .i_spi_clear, .i_ground_loss, .i_spi_wr_ss_disable, .i_spi_ss_disable,
    .i_spi_b_slew_rise, .o_fault_out, .o_reset_out_n, .o_dev_state, .o_stage_on, .o_spread_en,
    .o_phase, .o_b_vcode, .o_b_slew_rise, .o_fault_flags);

// ### tb/test_regulator_fault_supervisor.sv
// testbench: random and corner-case stimulus for the regulator fault supervisor
// assumes the host model answers faults and the checker is bound to the design
`timescale 1ns/10ps
module test_regulator_fault_supervisor
    import reg_sup_pkg::*;
;
    localparam int OT_CYC = 16 * 250;
    logic i_clock, i_nrst, i_otp_b_is_main, i_otp_b_freq_high, i_otp_b_oc_high, i_otp_boost_7v;
    logic i_otp_ov_reset_enable, i_spi_wr_vov_disable, i_spi_wr_ss_disable, i_seq_permit;
    logic i_wake_pin, i_vbat_b_ov, o_fault_out, o_reset_out_n, o_b_freq_high, o_boost_7v;
    logic o_b_oc_high, o_vbat_b_ov_en, o_vbat_b_ov_status, arm, main, oven, permit;
    logic [CODE_W-1:0] i_otp_b_vcode, i_otp_c_vcode, i_otp_d_vcode, o_b_vcode, o_c_vcode, o_d_vcode;
    logic [NUM_CH-1:0] i_otp_reset_list, i_spi_ss_disable, i_spi_pg_10pct, i_spi_enable, i_pg_ok;
    logic [NUM_CH-1:0] i_over_temp, i_oc_limit_hit, i_sw_cycle, i_ground_loss, o_stage_on;
    logic [NUM_CH-1:0] o_spread_en, o_pg_10pct, o_pg_status;
    logic [NUM_CH-1:0][SS_W-1:0] i_spi_softstart, o_softstart;
    logic [SLEW_W-1:0] i_spi_b_slew_rise, i_spi_b_slew_fall, o_b_slew_rise, o_b_slew_fall;
    logic [NUM_CH-1:0][THR_W-1:0] i_spi_uv_thr, i_spi_ov_thr, i_vout_level;
    logic [NUM_CH-1:0][F_W-1:0] i_spi_clear, o_fault_flags;
    logic [NUM_CH-1:0][PHASE_W-1:0] o_phase;
    logic [1:0] o_dev_state;
    logic [7:0] dly, nom;
    int fails, compares, seed, rlow, fhi, ev;

    regulator_fault_supervisor regulator_fault_supervisor_i (.*);
    host_model host_model_i (.i_clock(i_clock), .i_nrst(i_nrst), .i_arm(arm), .i_delay(dly),
        .i_fault_out(o_fault_out), .i_flags(o_fault_flags), .o_clear(i_spi_clear));

    task automatic cyc(input int n);
        repeat (n) @(posedge i_clock);
    endtask
    task automatic chk(input logic [31:0] act, input logic [31:0] exp);
        compares++;
        if (act !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h want %h", $time, act, exp);
        end
    endtask
    task automatic give_verdict;
        if (fails == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic watch(input int n);
        rlow = 0;
        fhi = 0;
        repeat (n) begin
            cyc(1);
            rlow += int'(o_reset_out_n === 1'b0);
            fhi += int'(o_fault_out === 1'b1);
        end
    endtask
    task automatic settle;
        arm <= 1'b1;
        repeat (400) if (o_fault_flags !== '0 || o_stage_on !== 4'hf) cyc(1);
        arm <= 1'b0;
        chk(o_stage_on, 4'hf);
    endtask
    task automatic fault_ev(input int kind, input int ch);
        logic ex;
        i_vout_level[ch] <= (kind == F_OV) ? 8'hf0 : 8'h10;
        watch(8);
        i_vout_level[ch] <= nom;
        if (kind == F_UV) ex = (ch == CH_B && main) || (i_otp_reset_list[ch] && permit);
        else ex = oven && i_otp_reset_list[ch];
        chk({o_fault_flags[ch][kind], fhi > 0}, 2'b11);
        chk(rlow > 0, ex);
        settle;
    endtask
    task automatic oc_run(input int n, input logic hit);
        repeat (n) begin
            i_oc_limit_hit[CH_C] <= hit;
            cyc(3);
            i_sw_cycle[CH_C] <= 1'b1;
            cyc(3);
            i_sw_cycle[CH_C] <= 1'b0;
        end
        cyc(4);
    endtask
    task automatic setup(input int p);
        main = p < 2;
        oven = p > 0;
        permit = (p < 2) ? 1'b1 : 1'($random(seed));
        nom = 8'h60 + 8'($random(seed) & 32'h3f);
        dly = 8'($random(seed) & 32'hf);
        i_nrst <= 1'b0;
        i_otp_b_is_main <= main;
        i_otp_ov_reset_enable <= oven;
        i_seq_permit <= permit;
        i_otp_reset_list <= (p < 2) ? 4'hf : 4'($random(seed));
        {i_otp_b_vcode, i_otp_c_vcode, i_otp_d_vcode, i_otp_b_freq_high, i_otp_b_oc_high,
            i_otp_boost_7v} <= 12'($random(seed));
        {i_spi_softstart, i_spi_b_slew_rise, i_spi_b_slew_fall, i_spi_pg_10pct} <= 16'($random(seed));
        {i_spi_wr_vov_disable, i_spi_wr_ss_disable, i_spi_ss_disable, i_spi_enable} <= '0;
        {i_wake_pin, i_vbat_b_ov, i_over_temp, i_oc_limit_hit, i_sw_cycle, i_ground_loss} <= '0;
        i_pg_ok <= 4'hf;
        i_spi_uv_thr <= {4{8'h40}};
        i_spi_ov_thr <= {4{8'hc0}};
        i_vout_level <= {4{nom}};
        cyc(8);
        i_nrst <= 1'b1;
        cyc(2);
    endtask

    initial begin
        i_clock = 1'b0;
        forever #2 i_clock = ~i_clock;
    end
    initial begin
        #300000;
        fails++;
        give_verdict();
    end
    initial begin
        seed = 32'h2c17;
        fails = 0;
        compares = 0;
        arm = 1'b0;
        for (int p = 0; p < 3; p++) begin
            setup(p);
            chk({o_spread_en, o_vbat_b_ov_en, o_phase}, 13'h1ff6);
            chk({o_b_vcode, o_c_vcode, o_d_vcode}, {i_otp_b_vcode, i_otp_c_vcode, i_otp_d_vcode});
            chk({o_b_freq_high, o_b_oc_high, o_boost_7v}, {i_otp_b_freq_high, i_otp_b_oc_high, i_otp_boost_7v});
            chk({o_softstart, o_b_slew_rise, o_b_slew_fall, o_pg_10pct}, {i_spi_softstart, i_spi_b_slew_rise, i_spi_b_slew_fall, i_spi_pg_10pct});
            i_spi_enable <= 4'hf;
            cyc(6);
            chk(o_stage_on[CH_B], !main);
            i_wake_pin <= 1'b1;
            repeat (30) if (o_stage_on !== 4'hf) cyc(1);
            chk(o_stage_on, 4'hf);
            i_pg_ok <= {3'($random(seed)), 1'b1};
            cyc(5);
            chk(o_pg_status, {i_pg_ok[3:1], !main});
            i_pg_ok <= 4'hf;
            for (int k = 0; k < 8; k++) fault_ev(k / 4, k % 4);
            if (p == 0) begin
                i_over_temp[CH_BOOST] <= 1'b1;
                cyc(OT_CYC - 10);
                i_over_temp[CH_BOOST] <= 1'b0;
                cyc(6);
                chk(o_fault_flags[CH_BOOST][F_OT], 1'b0);
                i_over_temp[CH_BOOST] <= 1'b1;
                cyc(OT_CYC + 8);
                chk({o_fault_flags[CH_BOOST][F_OT], o_stage_on[CH_BOOST]}, 2'b10);
                i_over_temp[CH_BOOST] <= 1'b0;
                settle;
            end
            oc_run(6, 1'b1);
            oc_run(1, 1'b0);
            oc_run(6, 1'b1);
            chk(o_fault_flags[CH_C][F_OC], 1'b0);
            oc_run(1, 1'b1);
            chk(o_fault_flags[CH_C][F_OC], 1'b1);
            oc_run(1, 1'b0);
            settle;
            i_ground_loss[CH_D] <= 1'b1;
            arm <= 1'b1;
            cyc(40);
            arm <= 1'b0;
            chk({o_fault_flags[CH_D][F_GL], o_stage_on[CH_D]}, 2'b10);
            i_ground_loss[CH_D] <= 1'b0;
            cyc(10);
            chk(o_stage_on[CH_D], 1'b0);
            settle;
            if (main) begin
                i_ground_loss[CH_B] <= 1'b1;
                arm <= 1'b1;
                watch(40);
                chk({o_stage_on, rlow > 0, fhi > 0}, 6'h03);
                i_ground_loss[CH_B] <= 1'b0;
                settle;
            end
            ev = $random(seed);
            i_spi_ss_disable <= 4'(ev);
            i_spi_wr_ss_disable <= 1'b1;
            i_vbat_b_ov <= 1'b1;
            cyc(1);
            i_spi_wr_ss_disable <= 1'b0;
            cyc(5);
            chk({o_spread_en, o_vbat_b_ov_status}, {~4'(ev), 1'b1});
            i_spi_wr_vov_disable <= 1'b1;
            cyc(1);
            i_spi_wr_vov_disable <= 1'b0;
            cyc(2);
            chk(o_vbat_b_ov_en, 1'b0);
        end
        give_verdict();
    end
endmodule // test_regulator_fault_supervisor

// ### verilog/fault_latch.sv
// module: sticky fault flags for all channels, set wins over clear
// assumes events and clears are synchronous to i_clock
`timescale 1ns/10ps
module fault_latch
    import reg_sup_pkg::*;
(
    input  wire logic i_clock,
    input  wire logic i_nrst,
    reg_sup_if.latch  bus
);
    logic [NUM_CH-1:0][F_W-1:0] flag;
    logic [NUM_CH-1:0][F_W-1:0] next_flag;

    assign next_flag = bus.set_event | (flag & ~bus.clear_req);
    assign bus.flags = flag;

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            flag <= '0;
        end else begin
            flag <= next_flag;
        end
    end
endmodule // fault_latch

// ### verilog/reg_sup_if.sv
// interface: per-channel fault events passing from the top to the fault latch module
// assumes one clock shared by both ends
`timescale 1ns/10ps
interface reg_sup_if;
    import reg_sup_pkg::*;
    logic [NUM_CH-1:0][F_W-1:0] set_event;
    logic [NUM_CH-1:0][F_W-1:0] clear_req;
    logic [NUM_CH-1:0][F_W-1:0] flags;
    modport top   (output set_event, output clear_req, input flags);
    modport latch (input set_event, input clear_req, output flags);
endinterface

// ### verilog/reg_sup_pkg.sv
// package: constants and types shared by the regulator fault supervisor
// assumes a 250 MHz clock and four regulator channels indexed b, c, d, boost
package reg_sup_pkg;
    localparam int  NUM_CH         = 4;
    localparam int  CH_B           = 0;
    localparam int  CH_C           = 1;
    localparam int  CH_D           = 2;
    localparam int  CH_BOOST       = 3;
    localparam int  CLK_MHZ        = 250;
    localparam int  OT_FILTER_US   = 16;
    localparam int  OT_FILTER_CYC  = OT_FILTER_US * CLK_MHZ;
    localparam int  OT_CNT_W       = 12;
    localparam int  OC_LIMIT_CYC   = 7;
    localparam int  OC_CNT_W       = 3;
    localparam int  THR_W          = 8;
    localparam int  CODE_W         = 3;
    localparam int  SS_W           = 2;
    localparam int  SLEW_W         = 2;
    localparam int  PHASE_W        = 2;
    // phase offsets in quarter turns versus pre_regulator_a
    localparam logic [PHASE_W-1:0] PHASE_B     = 2'h2;
    localparam logic [PHASE_W-1:0] PHASE_C     = 2'h1;
    localparam logic [PHASE_W-1:0] PHASE_D     = 2'h3;
    localparam logic [PHASE_W-1:0] PHASE_BOOST = 2'h3;
    localparam logic               SS_DEFAULT  = 1'h1;
    localparam logic               VOV_DEFAULT = 1'h1;
    // fault bit positions within a channel's status word
    localparam int  F_UV = 0;
    localparam int  F_OV = 1;
    localparam int  F_OT = 2;
    localparam int  F_OC = 3;
    localparam int  F_GL = 4;
    localparam int  F_W  = 5;
    typedef enum logic [1:0] {
        ST_OFF     = 2'b00,
        ST_ON      = 2'b01,
        ST_RECOVER = 2'b10
    } dev_state_t;
endpackage

// ### verilog/regulator_fault_supervisor.sv
// module: fault supervision and configuration of pre_regulator_b, post_regulator_c/d, boost
// assumes analog comparator flags arrive asynchronously and pass a two-stage synchroniser
`timescale 1ns/10ps

module regulator_fault_supervisor
    import reg_sup_pkg::*;
(
    input  wire logic                         i_clock,
    input  wire logic                         i_nrst,
    // otp selections
    input  wire logic                         i_otp_b_is_main,
    input  wire logic                         i_otp_b_freq_high,
    input  wire logic [CODE_W-1:0]            i_otp_b_vcode,
    input  wire logic                         i_otp_b_oc_high,
    input  wire logic [CODE_W-1:0]            i_otp_c_vcode,
    input  wire logic [CODE_W-1:0]            i_otp_d_vcode,
    input  wire logic                         i_otp_boost_7v,
    input  wire logic                         i_otp_ov_reset_enable,
    input  wire logic [NUM_CH-1:0]            i_otp_reset_list,
    // spi settings
    input  wire logic                         i_spi_wr_vov_disable,
    input  wire logic                         i_spi_wr_ss_disable,
    input  wire logic [NUM_CH-1:0]            i_spi_ss_disable,
    input  wire logic [NUM_CH-1:0][SS_W-1:0]  i_spi_softstart,
    input  wire logic [SLEW_W-1:0]            i_spi_b_slew_rise,
    input  wire logic [SLEW_W-1:0]            i_spi_b_slew_fall,
    input  wire logic [NUM_CH-1:0][THR_W-1:0] i_spi_uv_thr,
    input  wire logic [NUM_CH-1:0][THR_W-1:0] i_spi_ov_thr,
    input  wire logic [NUM_CH-1:0]            i_spi_pg_10pct,
    input  wire logic [NUM_CH-1:0]            i_spi_enable,
    input  wire logic [NUM_CH-1:0][F_W-1:0]   i_spi_clear,
    input  wire logic                         i_seq_permit,
    // analog side
    input  wire logic                         i_wake_pin,
    input  wire logic                         i_vbat_b_ov,
    input  wire logic [NUM_CH-1:0][THR_W-1:0] i_vout_level,
    input  wire logic [NUM_CH-1:0]            i_pg_ok,
    input  wire logic [NUM_CH-1:0]            i_over_temp,
    input  wire logic [NUM_CH-1:0]            i_oc_limit_hit,
    input  wire logic [NUM_CH-1:0]            i_sw_cycle,
    input  wire logic [NUM_CH-1:0]            i_ground_loss,
    // outputs
    output logic                              o_fault_out,
    output logic                              o_reset_out_n,
    output logic [1:0]                        o_dev_state,
    output logic [NUM_CH-1:0]                 o_stage_on,
    output logic [NUM_CH-1:0]                 o_spread_en,
    output logic [NUM_CH-1:0][PHASE_W-1:0]    o_phase,
    output logic                              o_b_freq_high,
    output logic [CODE_W-1:0]                 o_b_vcode,
    output logic [CODE_W-1:0]                 o_c_vcode,
    output logic [CODE_W-1:0]                 o_d_vcode,
    output logic                              o_boost_7v,
    output logic                              o_b_oc_high,
    output logic [NUM_CH-1:0][SS_W-1:0]       o_softstart,
    output logic [SLEW_W-1:0]                 o_b_slew_rise,
    output logic [SLEW_W-1:0]                 o_b_slew_fall,
    output logic                              o_vbat_b_ov_en,
    output logic                              o_vbat_b_ov_status,
    output logic [NUM_CH-1:0]                 o_pg_10pct,
    output logic [NUM_CH-1:0]                 o_pg_status,
    output logic [NUM_CH-1:0][F_W-1:0]        o_fault_flags
);
    // two-flop synchronisers for asynchronous analog flags
    localparam int SYNC_W = 2 + 5 * NUM_CH;
    logic [SYNC_W-1:0] sync_a;
    logic [SYNC_W-1:0] sync_b;
    logic              wake_s;
    logic              vbat_ov_s;
    logic [NUM_CH-1:0] pg_s;
    logic [NUM_CH-1:0] ot_s;
    logic [NUM_CH-1:0] oc_s;
    logic [NUM_CH-1:0] cyc_s;
    logic [NUM_CH-1:0] gl_s;

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            sync_a <= '0;
            sync_b <= '0;
        end else begin
            sync_a <= {i_wake_pin, i_vbat_b_ov, i_pg_ok, i_over_temp,
                       i_oc_limit_hit, i_sw_cycle, i_ground_loss};
            sync_b <= sync_a;
        end
    end
    assign {wake_s, vbat_ov_s, pg_s, ot_s, oc_s, cyc_s, gl_s} = sync_b;

    // configuration passes through registers, except the fixed phase offsets
    logic vov_en;
    logic [NUM_CH-1:0] spread;
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            vov_en <= VOV_DEFAULT;
            spread <= {NUM_CH{SS_DEFAULT}};
        end else begin
            if (i_spi_wr_vov_disable) begin
                vov_en <= 1'b0;
            end
            if (i_spi_wr_ss_disable) begin
                spread <= spread & ~i_spi_ss_disable;
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            o_b_freq_high <= 1'b0;
            o_b_vcode     <= '0;
            o_c_vcode     <= '0;
            o_d_vcode     <= '0;
            o_boost_7v    <= 1'b0;
            o_b_oc_high   <= 1'b0;
            o_softstart   <= '0;
            o_b_slew_rise <= '0;
            o_b_slew_fall <= '0;
            o_pg_10pct    <= '0;
        end else begin
            o_b_freq_high <= i_otp_b_freq_high;
            o_b_vcode     <= i_otp_b_vcode;
            o_c_vcode     <= i_otp_c_vcode;
            o_d_vcode     <= i_otp_d_vcode;
            o_boost_7v    <= i_otp_boost_7v;
            o_b_oc_high   <= i_otp_b_oc_high;
            o_softstart   <= i_spi_softstart;
            o_b_slew_rise <= i_spi_b_slew_rise;
            o_b_slew_fall <= i_spi_b_slew_fall;
            o_pg_10pct    <= i_spi_pg_10pct;
        end
    end
    assign o_spread_en    = spread;
    assign o_vbat_b_ov_en = vov_en;
    assign o_phase        = {PHASE_BOOST, PHASE_D, PHASE_C, PHASE_B};

    // device state machine
    dev_state_t state;
    dev_state_t next_state;
    logic       main_b;
    logic       reset_req;
    logic       main_gl;

    assign main_b  = i_otp_b_is_main;
    assign main_gl = main_b & gl_s[CH_B];

    always_comb begin
        next_state = state;
        case (state)
            ST_OFF:     if (main_b && wake_s && !main_gl) next_state = ST_ON;
            ST_ON:      if (reset_req || !wake_s) next_state = ST_RECOVER;
            ST_RECOVER: if (!reset_req && !main_gl) next_state = ST_OFF;
            default:    next_state = ST_OFF;
        endcase
    end
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            state <= ST_OFF;
        end else begin
            state <= next_state;
        end
    end
    assign o_dev_state = state;

    // per-channel monitors, filters and counters
    reg_sup_if fl ();
    fault_latch u_latch (
        .i_clock (i_clock),
        .i_nrst  (i_nrst),
        .bus     (fl)
    );

    logic [NUM_CH-1:0][OT_CNT_W-1:0] ot_cnt;
    logic [NUM_CH-1:0][OC_CNT_W-1:0] oc_cnt;
    logic [NUM_CH-1:0]               cyc_d;
    logic [NUM_CH-1:0]               uv_ev;
    logic [NUM_CH-1:0]               ov_ev;
    logic [NUM_CH-1:0]               ot_ev;
    logic [NUM_CH-1:0]               oc_ev;
    logic [NUM_CH-1:0]               uv_rst;
    logic [NUM_CH-1:0]               ov_rst;
    logic [NUM_CH-1:0]               gl_rst;
    logic [NUM_CH-1:0]               blocked;
    logic [NUM_CH-1:0]               stage;

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_ch
            logic cyc_rise;
            logic in_list;
            assign cyc_rise = cyc_s[g] & ~cyc_d[g];
            assign uv_ev[g] = stage[g] & (i_vout_level[g] < i_spi_uv_thr[g]);
            assign ov_ev[g] = i_vout_level[g] > i_spi_ov_thr[g];
            assign ot_ev[g] = ot_cnt[g] == OT_CNT_W'(OT_FILTER_CYC - 1) && ot_s[g];
            assign oc_ev[g] = cyc_rise && oc_s[g]
                              && oc_cnt[g] == OC_CNT_W'(OC_LIMIT_CYC - 1);
            assign in_list  = i_otp_reset_list[g] & i_spi_enable[g];
            assign uv_rst[g] = (g == CH_B && main_b) ? uv_ev[g]
                               : uv_ev[g] & in_list & i_seq_permit;
            assign ov_rst[g] = ov_ev[g] & i_otp_ov_reset_enable & in_list;
            assign gl_rst[g] = gl_s[g] & i_otp_reset_list[g] & i_seq_permit;
            // turn-on blocked by over_temp until its flag is cleared, by ground loss until the flag is cleared and the loss removed
            assign blocked[g] = fl.flags[g][F_OT] | fl.flags[g][F_GL] | gl_s[g]
                                | main_gl;
            assign stage[g] = i_spi_enable[g] & ~blocked[g]
                              & (state == ST_ON || (g != CH_B && !main_b) || !main_b);
            assign fl.set_event[g] = {gl_s[g], oc_ev[g], ot_ev[g], ov_ev[g], uv_ev[g]};
            assign fl.clear_req[g] = i_spi_clear[g];
            assign o_pg_status[g] = (g == CH_B && state == ST_ON) ? 1'b0 : pg_s[g];

            always_ff @(posedge i_clock or negedge i_nrst) begin
                if (!i_nrst) begin
                    ot_cnt[g] <= '0;
                    oc_cnt[g] <= '0;
                    cyc_d[g]  <= 1'b0;
                end else begin
                    cyc_d[g]  <= cyc_s[g];
                    if (!ot_s[g] || ot_ev[g]) begin
                        ot_cnt[g] <= '0;
                    end else begin
                        ot_cnt[g] <= ot_cnt[g] + 1'b1;
                    end
                    if (cyc_rise) begin
                        if (!oc_s[g] || oc_ev[g]) begin
                            oc_cnt[g] <= '0;
                        end else begin
                            oc_cnt[g] <= oc_cnt[g] + 1'b1;
                        end
                    end
                end
            end
        end
    endgenerate

    assign reset_req = |uv_rst | |ov_rst | |gl_rst | main_gl;

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            o_fault_out        <= 1'b0;
            o_reset_out_n      <= 1'b0;
            o_stage_on         <= '0;
            o_vbat_b_ov_status <= 1'b0;
        end else begin
            o_fault_out        <= |fl.flags | |fl.set_event;
            o_reset_out_n      <= ~(reset_req | state == ST_RECOVER);
            o_stage_on         <= stage;
            o_vbat_b_ov_status <= vov_en & vbat_ov_s;
        end
    end
    assign o_fault_flags = fl.flags;
endmodule // regulator_fault_supervisor
